// [bffm_defines.vh]
/*
  Constants of the bridge frame filter: register offsets, field positions,
  reset values and table sizes.
  Assumes inclusion by bare name from each design file that needs it.
*/
`ifndef BFFM_DEFINES_VH
`define BFFM_DEFINES_VH

// Register offsets (byte addresses on the 8-bit register port)
`define BFFM_REG_CTRL       8'h00
`define BFFM_REG_PAT_CFG    8'h04
`define BFFM_REG_STATUS     8'h08
`define BFFM_REG_FWD_CNT    8'h0C
`define BFFM_REG_DROP_CNT   8'h10
`define BFFM_TERM_BASE      8'h20
`define BFFM_ENTRY_BASE     8'h80

// Control register fields
`define BFFM_CTRL_NEG       0
`define BFFM_CTRL_PAT_EN    1
`define BFFM_CTRL_RST       2'h0

// Pattern configuration fields
`define BFFM_PAT_INV_LSB    0
`define BFFM_PAT_OR01       4
`define BFFM_PAT_OR23       5
`define BFFM_PAT_ORTOP      6
`define BFFM_PAT_EN1        7
`define BFFM_PAT_ENB        8
`define BFFM_PAT_EN3        9
`define BFFM_PAT_INV_ALL    10
`define BFFM_PAT_RST        11'h000

// Term configuration fields
`define BFFM_TERM_OFS_LSB   0
`define BFFM_TERM_LEN_LSB   16
`define BFFM_TERM_STRIDE    8'h08

// Entry layout
`define BFFM_ENT_LO         2'h0
`define BFFM_ENT_HI         2'h1
`define BFFM_ENT_FLAGS      2'h2
`define BFFM_ENT_LOC        2'h3
`define BFFM_FLAG_PRESENT   0
`define BFFM_FLAG_PERM      1
`define BFFM_FLAG_SRC_ACT   2
`define BFFM_FLAG_DST_ACT   3

// Sizes
`define BFFM_ENTRIES        4
`define BFFM_TERMS          4
`define BFFM_FIFO_DEPTH     32
`define BFFM_FIFO_AW        5
`define BFFM_DST_LAST       11'h005
`define BFFM_SRC_LAST       11'h00B

`endif

// [bffm_fifo.v]
/*
  Synchronous FIFO with valid/ready on both sides and registered flags.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module bffm_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_in,
  input  wire             arst_n_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  output wire [WIDTH-1:0] out_data_out,
  output wire             out_valid_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;
  reg [AW:0]      count;
  reg             not_full;
  wire            full;
  reg             empty;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;

  assign push          = in_valid_in & ~full;
  assign pop           = out_ready_in & ~empty;
  assign full          = ~not_full;
  assign in_ready_out  = not_full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem[rptr];

  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      next_count = count - {{AW{1'b0}}, 1'b1};
  end

  always @(posedge clk_in) begin
    if (push)
      mem[wptr] <= in_data_in;
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      not_full <= 1'b1;
      empty <= 1'b1;
    end else begin
      if (push)
        wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rptr <= rptr + {{(AW-1){1'b0}}, 1'b1};
      count <= next_count;
      not_full <= (next_count != DEPTH[AW:0]);
      empty <= (next_count == {(AW+1){1'b0}});
    end
  end
endmodule
`default_nettype wire

// [bffm_term.v]
/*
  One pattern term: compares frame octets from a given offset against
  up to four octets of a value, last octet in the least significant byte.
  Assumes octets arrive in order with their index, index 0 opening a frame.
*/
`timescale 1ns/100ps
`default_nettype none
module bffm_term (
  input  wire        clk_in,
  input  wire        arst_n_in,
  input  wire [7:0]  byte_in,
  input  wire [10:0] idx_in,
  input  wire        take_in,
  input  wire [10:0] offset_in,
  input  wire [2:0]  len_in,
  input  wire [31:0] value_in,
  output wire        match_out
);
  reg        ok;
  reg [2:0]  cnt;
  reg [7:0]  expb;
  wire [10:0] rel;
  wire [2:0]  sel;
  wire        inwin;
  wire        base_ok;
  wire [2:0]  base_cnt;

  assign rel      = idx_in - offset_in;
  assign inwin    = (idx_in >= offset_in) && (rel < {8'h00, len_in});
  assign sel      = len_in - 3'h1 - rel[2:0];
  assign base_ok  = (idx_in == 11'h000) ? 1'b1 : ok;
  assign base_cnt = (idx_in == 11'h000) ? 3'h0 : cnt;
  // A short frame never completes the count, so it never matches
  assign match_out = ok && (cnt == len_in) && (len_in != 3'h0);

  always @* begin
    case (sel)
      3'h0:    expb = value_in[7:0];
      3'h1:    expb = value_in[15:8];
      3'h2:    expb = value_in[23:16];
      3'h3:    expb = value_in[31:24];
      default: expb = 8'h00;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ok  <= 1'b0;
      cnt <= 3'h0;
    end else if (take_in) begin
      ok  <= base_ok & (~inwin | (byte_in == expb));
      cnt <= base_cnt + {2'h0, inwin};
    end
  end
endmodule
`default_nettype wire

// [bffm_top.v]
/*
  Bridge frame filter: local LAN frames pass through a FIFO toward the
  link, and for each frame a forward or discard decision is given from
  the permanent address table and the pattern expression.
  Assumes synchronous inputs on CLK_IN, a register master on a plain port
  and a downstream that joins each decision to the frame it follows.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bffm_defines.vh"
module bffm_top (
  input  wire        CLK_IN,
  input  wire        ARST_N_IN,
  input  wire [7:0]  RX_DATA_IN,
  input  wire        RX_VALID_IN,
  input  wire        RX_LAST_IN,
  output wire        RX_READY_OUT,
  output reg  [7:0]  TX_DATA_OUT,
  output reg         TX_VALID_OUT,
  output reg         TX_LAST_OUT,
  input  wire        TX_READY_IN,
  output reg         VERDICT_VALID_OUT,
  output reg         VERDICT_FWD_OUT,
  input  wire [7:0]  REG_ADDR_IN,
  input  wire [31:0] REG_WDATA_IN,
  input  wire        REG_WR_IN,
  input  wire        REG_RD_IN,
  output reg  [31:0] REG_RDATA_OUT
);
  // Configuration
  reg  [1:0]  ctrl;
  reg  [10:0] pat_cfg;
  reg  [10:0] term_ofs [0:`BFFM_TERMS-1];
  reg  [2:0]  term_len [0:`BFFM_TERMS-1];
  reg  [31:0] term_val [0:`BFFM_TERMS-1];
  reg  [47:0] ent_addr [0:`BFFM_ENTRIES-1];
  reg  [3:0]  ent_flags [0:`BFFM_ENTRIES-1];
  reg  [7:0]  ent_loc [0:`BFFM_ENTRIES-1];
  // Frame tracking
  reg  [10:0] idx;
  reg  [47:0] dst_addr;
  reg  [47:0] src_addr;
  reg         pend;
  reg         last_fwd;
  reg  [31:0] fwd_cnt;
  reg  [31:0] drop_cnt;
  reg  [31:0] next_rdata;
  reg         src_hit;
  reg         dst_hit;
  reg         src_armed;
  reg         dst_armed;
  reg         addr_fwd;
  reg         grp_a;
  reg         grp_b;
  reg         pat_res;
  reg         next_fwd;
  wire        take;
  wire [3:0]  tmatch;
  wire [3:0]  tval;
  wire [8:0]  fifo_out;
  wire        fifo_valid;
  wire        fifo_pop;
  wire        fifo_empty_n;
  wire        tx_free;
  integer     i;
  integer     j;
  integer     k;
  integer     m;

  assign take     = RX_VALID_IN & RX_READY_OUT;
  assign tx_free  = ~TX_VALID_OUT | TX_READY_IN;
  assign fifo_pop = tx_free & fifo_valid;
  assign fifo_empty_n = fifo_valid;

  // Every octet goes to the link; the verdict travels on its own port
  bffm_fifo #(
    .WIDTH (9),
    .DEPTH (`BFFM_FIFO_DEPTH),
    .AW    (`BFFM_FIFO_AW)
  ) u_fifo (
    .clk_in        (CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .in_data_in    ({RX_LAST_IN, RX_DATA_IN}),
    .in_valid_in   (RX_VALID_IN),
    .in_ready_out  (RX_READY_OUT),
    .out_data_out  (fifo_out),
    .out_valid_out (fifo_valid),
    .out_ready_in  (tx_free)
  );

  genvar g;
  generate
    for (g = 0; g < `BFFM_TERMS; g = g + 1) begin : g_term
      bffm_term u_term (
        .clk_in    (CLK_IN),
        .arst_n_in (ARST_N_IN),
        .byte_in   (RX_DATA_IN),
        .idx_in    (idx),
        .take_in   (take),
        .offset_in (term_ofs[g]),
        .len_in    (term_len[g]),
        .value_in  (term_val[g]),
        .match_out (tmatch[g])
      );
      // Per-term inversion
      assign tval[g] = tmatch[g] ^ pat_cfg[`BFFM_PAT_INV_LSB + g];
    end
  endgenerate

  // Address table lookup and pattern evaluation for the frame just ended
  always @* begin
    src_hit   = 1'b0;
    dst_hit   = 1'b0;
    src_armed = 1'b0;
    dst_armed = 1'b0;
    for (i = 0; i < `BFFM_ENTRIES; i = i + 1) begin
      if (ent_flags[i][`BFFM_FLAG_PRESENT]) begin
        if (ent_flags[i][`BFFM_FLAG_SRC_ACT]) begin
          src_armed = 1'b1;
          if (ent_addr[i] == src_addr)
            src_hit = 1'b1;
        end
        if (ent_flags[i][`BFFM_FLAG_DST_ACT]) begin
          dst_armed = 1'b1;
          if (ent_addr[i] == dst_addr)
            dst_hit = 1'b1;
        end
      end
    end
    if (ctrl[`BFFM_CTRL_NEG]) begin
      // Only listed addresses pass once any pass entry is armed
      if (src_armed | dst_armed)
        addr_fwd = src_hit | dst_hit;
      else
        addr_fwd = 1'b1;
    end else begin
      addr_fwd = ~(src_hit | dst_hit);
    end
    // Bracket groups first, then the joining operator
    if (pat_cfg[`BFFM_PAT_EN1])
      grp_a = pat_cfg[`BFFM_PAT_OR01] ? (tval[0] | tval[1])
                                      : (tval[0] & tval[1]);
    else
      grp_a = tval[0];
    if (pat_cfg[`BFFM_PAT_EN3])
      grp_b = pat_cfg[`BFFM_PAT_OR23] ? (tval[2] | tval[3])
                                      : (tval[2] & tval[3]);
    else
      grp_b = tval[2];
    if (pat_cfg[`BFFM_PAT_ENB])
      pat_res = pat_cfg[`BFFM_PAT_ORTOP] ? (grp_a | grp_b)
                                         : (grp_a & grp_b);
    else
      pat_res = grp_a;
    pat_res = pat_res ^ pat_cfg[`BFFM_PAT_INV_ALL];
    next_fwd = addr_fwd &
               ~(ctrl[`BFFM_CTRL_PAT_EN] & pat_res);
  end

  // Frame index and header capture
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      idx      <= 11'h000;
      dst_addr <= 48'h000000000000;
      src_addr <= 48'h000000000000;
      pend     <= 1'b0;
    end else begin
      pend <= take & RX_LAST_IN;
      if (take) begin
        if (RX_LAST_IN)
          idx <= 11'h000;
        else if (idx != 11'h7FF)
          idx <= idx + 11'h001;
        if (idx <= `BFFM_DST_LAST)
          dst_addr <= {dst_addr[39:0], RX_DATA_IN};
        else if (idx <= `BFFM_SRC_LAST)
          src_addr <= {src_addr[39:0], RX_DATA_IN};
      end
    end
  end

  // Decision output and counters
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      VERDICT_VALID_OUT <= 1'b0;
      VERDICT_FWD_OUT   <= 1'b0;
      last_fwd        <= 1'b0;
      fwd_cnt         <= 32'h00000000;
      drop_cnt        <= 32'h00000000;
    end else begin
      VERDICT_VALID_OUT <= pend;
      if (pend) begin
        VERDICT_FWD_OUT <= next_fwd;
        last_fwd        <= next_fwd;
        if (next_fwd)
          fwd_cnt <= fwd_cnt + 32'h00000001;
        else
          drop_cnt <= drop_cnt + 32'h00000001;
      end
    end
  end

  // Output stage
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      TX_DATA_OUT  <= 8'h00;
      TX_VALID_OUT <= 1'b0;
      TX_LAST_OUT  <= 1'b0;
    end else if (tx_free) begin
      TX_VALID_OUT <= fifo_pop;
      if (fifo_pop) begin
        TX_DATA_OUT <= fifo_out[7:0];
        TX_LAST_OUT <= fifo_out[8];
      end
    end
  end

  // Control and pattern configuration writes
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl    <= `BFFM_CTRL_RST;
      pat_cfg <= `BFFM_PAT_RST;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == `BFFM_REG_CTRL)
        ctrl <= REG_WDATA_IN[1:0];
      if (REG_ADDR_IN == `BFFM_REG_PAT_CFG)
        pat_cfg <= REG_WDATA_IN[10:0];
    end
  end

  // Pattern term writes
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (j = 0; j < `BFFM_TERMS; j = j + 1) begin
        term_ofs[j] <= 11'h000;
        term_len[j] <= 3'h0;
        term_val[j] <= 32'h00000000;
      end
    end else if (REG_WR_IN) begin
      // Offset and length share one word, the value sits in the next
      for (j = 0; j < `BFFM_TERMS; j = j + 1) begin
        if (REG_ADDR_IN == `BFFM_TERM_BASE + j * `BFFM_TERM_STRIDE) begin
          term_ofs[j] <= REG_WDATA_IN[`BFFM_TERM_OFS_LSB +: 11];
          term_len[j] <= REG_WDATA_IN[`BFFM_TERM_LEN_LSB +: 3];
        end
        if (REG_ADDR_IN == `BFFM_TERM_BASE + j * `BFFM_TERM_STRIDE + 4)
          term_val[j] <= REG_WDATA_IN;
      end
    end
  end

  // Address table writes
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (m = 0; m < `BFFM_ENTRIES; m = m + 1) begin
        ent_addr[m]  <= 48'h000000000000;
        ent_flags[m] <= 4'h0;
        ent_loc[m]   <= 8'h00;
      end
    end else if (REG_WR_IN) begin
      for (m = 0; m < `BFFM_ENTRIES; m = m + 1) begin
        if (REG_ADDR_IN[7:4] == (`BFFM_ENTRY_BASE >> 4) + m) begin
          case (REG_ADDR_IN[3:2])
            `BFFM_ENT_LO:
              ent_addr[m][31:0] <= REG_WDATA_IN;
            `BFFM_ENT_HI:
              ent_addr[m][47:32] <= REG_WDATA_IN[15:0];
            `BFFM_ENT_FLAGS: begin
              // An entry with an action is always held permanent
              ent_flags[m] <= {REG_WDATA_IN[3:2],
                               REG_WDATA_IN[1] | (|REG_WDATA_IN[3:2]),
                               REG_WDATA_IN[0]};
            end
            // A location makes an unknown address known and permanent
            `BFFM_ENT_LOC: begin
              ent_loc[m] <= REG_WDATA_IN[7:0];
              ent_flags[m][`BFFM_FLAG_PRESENT] <= 1'b1;
              ent_flags[m][`BFFM_FLAG_PERM]    <= 1'b1;
            end
            default: ent_loc[m] <= ent_loc[m];
          endcase
        end
      end
    end
  end

  // Register reads, data valid in the following cycle
  always @* begin
    next_rdata = 32'h00000000;
    case (REG_ADDR_IN)
      `BFFM_REG_CTRL:     next_rdata = {30'h00000000, ctrl};
      `BFFM_REG_PAT_CFG:  next_rdata = {21'h000000, pat_cfg};
      `BFFM_REG_STATUS:
        next_rdata = {29'h00000000, last_fwd, ~RX_READY_OUT,
                      ~fifo_empty_n};
      `BFFM_REG_FWD_CNT:  next_rdata = fwd_cnt;
      `BFFM_REG_DROP_CNT: next_rdata = drop_cnt;
      default:            next_rdata = 32'h00000000;
    endcase
    // Term and table words override the fixed map
    for (k = 0; k < `BFFM_TERMS; k = k + 1) begin
      if (REG_ADDR_IN == `BFFM_TERM_BASE + k * `BFFM_TERM_STRIDE)
        next_rdata = {13'h0000, term_len[k], 5'h00, term_ofs[k]};
      if (REG_ADDR_IN == `BFFM_TERM_BASE + k * `BFFM_TERM_STRIDE + 4)
        next_rdata = term_val[k];
    end
    for (k = 0; k < `BFFM_ENTRIES; k = k + 1) begin
      if (REG_ADDR_IN[7:4] == (`BFFM_ENTRY_BASE >> 4) + k) begin
        case (REG_ADDR_IN[3:2])
          `BFFM_ENT_LO:    next_rdata = ent_addr[k][31:0];
          `BFFM_ENT_HI:    next_rdata = {16'h0000, ent_addr[k][47:32]};
          `BFFM_ENT_FLAGS: next_rdata = {28'h0000000, ent_flags[k]};
          default:         next_rdata = {24'h000000, ent_loc[k]};
        endcase
      end
    end
  end

  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN)
      REG_RDATA_OUT <= 32'h00000000;
    else if (REG_RD_IN)
      REG_RDATA_OUT <= next_rdata;
    else
      REG_RDATA_OUT <= 32'h00000000;
  end
endmodule
`default_nettype wire

// [bffm_chk.sv]
/*
  Port checker for the bridge frame filter.
  Assumes one clock CLK_IN and the active-low reset ARST_N_IN.
*/
`timescale 1ns/100ps
`default_nettype none
module bffm_chk (
  input wire logic        CLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic [7:0]  RX_DATA_IN,
  input wire logic        RX_VALID_IN,
  input wire logic        RX_LAST_IN,
  input wire logic        RX_READY_OUT,
  input wire logic [7:0]  TX_DATA_OUT,
  input wire logic        TX_VALID_OUT,
  input wire logic        TX_LAST_OUT,
  input wire logic        TX_READY_IN,
  input wire logic        VERDICT_VALID_OUT,
  input wire logic        VERDICT_FWD_OUT,
  input wire logic [7:0]  REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire logic take_last = RX_VALID_IN && RX_READY_OUT && RX_LAST_IN;
  sequence s_ctrl_wr_rd;
    REG_WR_IN && REG_ADDR_IN == 8'h00 ##1 !REG_WR_IN
      ##1 REG_RD_IN && REG_ADDR_IN == 8'h00;
  endsequence
  sequence s_status_rd;
    REG_RD_IN && REG_ADDR_IN == 8'h08 && !VERDICT_VALID_OUT
      ##1 !VERDICT_VALID_OUT;
  endsequence
  chk_verdict_after_last: assert property (
    take_last |-> ##2 VERDICT_VALID_OUT)
    else $error("decision missing after last octet");
  chk_verdict_has_cause: assert property (
    VERDICT_VALID_OUT |-> $past(take_last, 2))
    else $error("decision without a finished frame");
  chk_fwd_held: assert property (
    !VERDICT_VALID_OUT |-> $stable(VERDICT_FWD_OUT))
    else $error("forward flag changed between decisions");
  chk_ctrl_readback: assert property (
    s_ctrl_wr_rd |=> REG_RDATA_OUT[1:0] == $past(REG_WDATA_IN[1:0], 3))
    else $error("control readback differs");
  chk_status_fwd: assert property (
    s_status_rd |-> REG_RDATA_OUT[2] == VERDICT_FWD_OUT)
    else $error("status forward bit differs");
  chk_rd_idle_zero: assert property (
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property (
    REG_RD_IN && REG_ADDR_IN == 8'h14 |=> REG_RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  chk_tx_held: assert property (
    TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT)
      && $stable(TX_LAST_OUT))
    else $error("link octet dropped while stalled");
  chk_ready_fall: assert property (
    $fell(RX_READY_OUT) |-> $past(RX_VALID_IN))
    else $error("ready fell without an octet taken");
endmodule
bind bffm_top bffm_chk bffm_chk_inst (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .RX_DATA_IN(RX_DATA_IN),
  .RX_VALID_IN(RX_VALID_IN), .RX_LAST_IN(RX_LAST_IN),
  .RX_READY_OUT(RX_READY_OUT), .TX_DATA_OUT(TX_DATA_OUT),
  .TX_VALID_OUT(TX_VALID_OUT), .TX_LAST_OUT(TX_LAST_OUT),
  .TX_READY_IN(TX_READY_IN), .VERDICT_VALID_OUT(VERDICT_VALID_OUT),
  .VERDICT_FWD_OUT(VERDICT_FWD_OUT), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT));
`default_nettype wire

// [bffm_sink.sv]
/*
  Link-side sink: accepts octets at full or half rate, or stalls.
  Assumes the filter's clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module bffm_sink (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  tx_data_in,
  input  wire logic        tx_valid_in,
  input  wire logic        tx_last_in,
  input  wire logic        stall_in,
  input  wire logic        fast_in,
  output logic             tx_ready_out,
  output logic [15:0]      n_octets_out,
  output logic [15:0]      n_frames_out,
  output logic [15:0]      sum_out
);
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_ready_out <= 1'b0;
      n_octets_out <= 16'h0000;
      n_frames_out <= 16'h0000;
      sum_out <= 16'h0000;
    end else begin
      tx_ready_out <= !stall_in && (fast_in || !tx_ready_out);
      if (tx_valid_in && tx_ready_out) begin
        n_octets_out <= n_octets_out + 16'h0001;
        sum_out <= sum_out + {8'h00, tx_data_in};
        if (tx_last_in) begin
          n_frames_out <= n_frames_out + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
/*
  Testbench of the bridge frame filter: register and frame tasks.
  Assumes the link sink model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bffm_defines.vh"
module tb_top;
  logic        clk, arst_n, rx_valid, rx_last, stall, fast, reg_wr, reg_rd;
  logic [7:0]  rx_data, reg_addr;
  logic [31:0] reg_wdata;
  wire  [7:0]  tx_data;
  wire         tx_valid, tx_last, tx_ready, rx_ready, verdict_valid;
  wire         verdict_fwd;
  wire  [31:0] reg_rdata;
  wire  [15:0] n_oct, n_frm, sum;
  logic [15:0] exp_sum;
  logic        saw_full;
  int          n_errors, tests_run, cycles, n_fwd, n_drop, n_soct, n_sfrm;
  localparam logic [47:0] A = 48'h010203040506, B = 48'h0A0B0C0D0E0F;
  localparam logic [47:0] H = 48'h000001020304, O = 48'h000001020399;
  // Pattern cases: config, octet 12, octet 14, forward
  localparam logic [27:0] PT [11] = '{
    {11'h080, 8'h80, 8'h24, 1'b0}, {11'h080, 8'h80, 8'h32, 1'b1},
    {11'h080, 8'h81, 8'h24, 1'b1}, {11'h090, 8'h81, 8'h24, 1'b0},
    {11'h090, 8'h80, 8'h32, 1'b0}, {11'h090, 8'h81, 8'h32, 1'b1},
    {11'h320, 8'h80, 8'h24, 1'b0}, {11'h320, 8'h80, 8'h32, 1'b0},
    {11'h320, 8'h80, 8'h33, 1'b1}, {11'h320, 8'h81, 8'h24, 1'b1},
    {11'h480, 8'h80, 8'h24, 1'b1}};
  localparam logic [7:0] TV [4] = '{8'h80, 8'h24, 8'h24, 8'h32};
  bffm_top bffm_top_inst (.CLK_IN(clk), .ARST_N_IN(arst_n),
    .RX_DATA_IN(rx_data), .RX_VALID_IN(rx_valid), .RX_LAST_IN(rx_last),
    .RX_READY_OUT(rx_ready), .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid),
    .TX_LAST_OUT(tx_last), .TX_READY_IN(tx_ready),
    .VERDICT_VALID_OUT(verdict_valid), .VERDICT_FWD_OUT(verdict_fwd),
    .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_RDATA_OUT(reg_rdata));
  bffm_sink bffm_sink_inst (.clk_in(clk), .arst_n_in(arst_n),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_last_in(tx_last),
    .stall_in(stall), .fast_in(fast), .tx_ready_out(tx_ready),
    .n_octets_out(n_oct), .n_frames_out(n_frm), .sum_out(sum));
  task automatic results;
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp("register read", e, reg_rdata);
  endtask
  // Sends one frame and checks the decision in the cycle in which it stands
  task automatic frame(input logic [47:0] d, s, input logic [31:0] w,
                       input int len, input logic fwd);
    logic [127:0] hdr;
    logic [7:0]   b;
    logic         ok;
    hdr = {d, s, w};
    @(posedge clk);
    for (int i = 0; i < len; i++) begin
      b = (i < 16) ? hdr[127-8*i -: 8] : 8'(i);
      exp_sum = exp_sum + {8'h00, b};
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_last <= (i == len - 1);
      do begin
        @(negedge clk);
        ok = rx_ready;
        saw_full = saw_full | !ok;
        @(posedge clk);
      end while (!ok);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    cmp("decision valid", 32'h1, {31'h0, verdict_valid});
    cmp("decision forward", {31'h0, fwd}, {31'h0, verdict_fwd});
    if (fwd) n_fwd++;
    else n_drop++;
    n_soct += len;
    n_sfrm++;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    {arst_n, rx_valid, rx_last, reg_wr, reg_rd, stall, saw_full} = '0;
    {rx_data, reg_addr, reg_wdata, exp_sum} = '0;
    fast = 1'b1;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdc(`BFFM_REG_CTRL, 32'h0);
    rdc(`BFFM_REG_PAT_CFG, 32'h0);
    rdc(8'h14, 32'h0);
    rdc(`BFFM_REG_STATUS, 32'h1);
    frame(H, A, 32'h0, 16, 1'b1);
    wr(8'h80, 32'h03040506);
    wr(8'h84, 32'h00000102);
    wr(8'h8C, 32'h00000001);
    rdc(8'h88, 32'h3);
    rdc(8'h8C, 32'h1);
    wr(8'h88, 32'h5);
    rdc(8'h88, 32'h7);
    frame(H, A, 32'h0, 16, 1'b0);
    frame(H, B, 32'h0, 16, 1'b1);
    wr(`BFFM_REG_CTRL, 32'h1);
    rdc(`BFFM_REG_CTRL, 32'h1);
    frame(H, A, 32'h0, 16, 1'b1);
    frame(H, B, 32'h0, 16, 1'b0);
    wr(8'h88, 32'h0);
    rdc(8'h88, 32'h0);
    wr(8'h90, 32'h01020304);
    wr(8'h98, 32'h9);
    frame(H, B, 32'h0, 16, 1'b1);
    frame(O, B, 32'h0, 16, 1'b0);
    wr(`BFFM_REG_CTRL, 32'h0);
    frame(H, B, 32'h0, 16, 1'b0);
    frame(O, B, 32'h0, 16, 1'b1);
    wr(8'h98, 32'h0);
    wr(`BFFM_REG_CTRL, 32'h2);
    wr(8'h20, 32'h0002000C);
    wr(8'h24, 32'h00000800);
    frame(H, B, 32'h08000000, 16, 1'b0);
    frame(H, B, 32'h08010000, 16, 1'b1);
    wr(8'h20, 32'h0001000C);
    wr(8'h24, 32'h00000008);
    frame(H, B, 32'h08010000, 16, 1'b0);
    wr(`BFFM_REG_PAT_CFG, 32'h1);
    frame(H, B, 32'h08010000, 16, 1'b1);
    frame(H, B, 32'h09000000, 16, 1'b0);
    for (int t = 0; t < 4; t++) begin
      wr(8'(8'h20 + 8 * t), (t == 0) ? 32'h0001000C : 32'h0001000E);
      wr(8'(8'h24 + 8 * t), {24'h0, TV[t]});
    end
    for (int k = 0; k < 11; k++) begin
      wr(`BFFM_REG_PAT_CFG, {21'h0, PT[k][27:17]});
      frame(H, B, {PT[k][16:9], 8'h00, PT[k][8:1], 8'h00}, 16,
            PT[k][0]);
    end
    wr(`BFFM_REG_PAT_CFG, 32'h0);
    wr(`BFFM_REG_CTRL, 32'h0);
    stall <= 1'b1;
    saw_full = 1'b0;
    fork
      frame(H, B, 32'h0, 40, 1'b1);
      begin
        repeat (60) @(posedge clk);
        stall <= 1'b0;
        fast <= 1'b0;
      end
    join
    cmp("fifo refused", 32'h1, {31'h0, saw_full});
    repeat (120) @(posedge clk);
    @(negedge clk);
    cmp("link octets", 32'(n_soct), {16'h0, n_oct});
    cmp("link frames", 32'(n_sfrm), {16'h0, n_frm});
    cmp("link sum", {16'h0, exp_sum}, {16'h0, sum});
    rdc(`BFFM_REG_STATUS, 32'h5);
    rdc(`BFFM_REG_FWD_CNT, 32'(n_fwd));
    rdc(`BFFM_REG_DROP_CNT, 32'(n_drop));
    results();
  end
endmodule
`default_nettype wire
